//--- eec_pkg.sv
/*
 * Shared constants and types for the three-wire serial memory link.
 * Assumes both ends run on one 250 MHz core clock.
 */
package eec_pkg;
    localparam int CORE_MHZ = 250;
    // shift clock half period and chip select low time, least times
    localparam int T_SKH_NS = 250;
    localparam int SKH_CYC  = (T_SKH_NS * CORE_MHZ + 999) / 1000;
    localparam int T_CS_NS  = 250;
    localparam int CS_CYC   = (T_CS_NS * CORE_MHZ + 999) / 1000;
    // program cycle, longest time
    localparam int T_WP_MS  = 10;
    localparam int WP_CYC   = T_WP_MS * CORE_MHZ * 1000;

    localparam logic [1:0] OP_SUB   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_LOCK   = 2'h0;
    localparam logic [1:0] SUB_FILL   = 2'h1;
    localparam logic [1:0] SUB_CLEAR  = 2'h2;
    localparam logic [1:0] SUB_UNLOCK = 2'h3;

    localparam logic [4:0] ABITS_X8  = 5'h09;
    localparam logic [4:0] ABITS_X16 = 5'h08;
    localparam logic [4:0] DBITS_X8  = 5'h08;
    localparam logic [4:0] DBITS_X16 = 5'h10;
    localparam logic [4:0] HEAD_BITS = 5'h03;
    localparam int         FRAME_W   = 28;
    localparam int         MEM_BYTES = 512;
    localparam logic [7:0] ERASED    = 8'hFF;

    typedef enum logic [2:0] {
        EEC_READ, EEC_UNLOCK, EEC_LOCK, EEC_ERASE, EEC_WRITE, EEC_CLEAR, EEC_FILL
    } eec_cmd_t;
endpackage : eec_pkg

//--- eec_link_if.sv
/*
 * Three-wire link between the memory end and the controlling end.
 * Assumes both ends share core_clk; every wire has one driver.
 */
`timescale 1ns/1ns
interface eec_link_if;
    logic chip_select;
    logic shift_clock;
    logic serial_in;
    logic serial_out;
    logic width_select_pin;

    modport dev (input chip_select, input shift_clock, input serial_in,
                 input width_select_pin, output serial_out);
    modport host (output chip_select, output shift_clock, output serial_in,
                  output width_select_pin, input serial_out);
endinterface : eec_link_if

//--- eec_device.sv
/*
 * Memory end: decodes serial commands and keeps a 512 byte array.
 * Assumes link pins are asynchronous to core_clk and the shift clock
 * half period spans many core cycles.
 */
`timescale 1ns/1ns
// Functional notes
// - lead one, two-bit opcode, then address
// - opcode 10 reads addressed word out
// - sub-code 11 unlocks programming
// - opcode 11 erases location when unlocked
// - opcode 01 writes following data word
// - sub-code 10 erases whole array
// - sub-code 01 fills array with data word
// - sub-code 00 locks programming again
// - host clocks full address field always
// - width pin high selects sixteen-bit words
// - dummy zero during last address bit
// - status low while busy, high after
module eec_device #(
    parameter logic [21:0] PROG_CYCLES = 22'(eec_pkg::WP_CYC)
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    eec_link_if.dev   link,
    output logic      unlocked,
    output logic      busy
);
    typedef enum logic [2:0] {S_IDLE, S_OP, S_ADDR, S_DATA, S_READ, S_SKIP} eec_dst_t;

    logic [2:0]  cs_s, sk_s, si_s, org_s;
    eec_dst_t    st_r, st_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [1:0]  op_r, op_nxt;
    logic [8:0]  addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt;
    logic        dout_r, dout_nxt;
    logic        unl_r, unl_nxt;
    logic        busy_r, busy_nxt;
    logic        stat_r, stat_nxt;
    logic [21:0] wcnt_r, wcnt_nxt;
    logic [7:0]  mem_r [eec_pkg::MEM_BYTES], mem_nxt [eec_pkg::MEM_BYTES];
    logic        cs, rise, cs_fall, si, x16;
    logic [4:0]  abits, dbits;
    logic [8:0]  a_sh, na, wa;
    logic [15:0] d_sh, wv, rw;
    logic [1:0]  top2;
    logic        do_wr, do_all;

    // pins pass two flops; the third stage only feeds edge detection
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s  <= 3'h0;
            sk_s  <= 3'h0;
            si_s  <= 3'h0;
            org_s <= 3'h0;
        end else begin
            cs_s  <= {cs_s[1:0], link.chip_select};
            sk_s  <= {sk_s[1:0], link.shift_clock};
            si_s  <= {si_s[1:0], link.serial_in};
            org_s <= {org_s[1:0], link.width_select_pin};
        end
    end

    assign cs      = cs_s[1];
    assign cs_fall = cs_s[2] & ~cs_s[1];
    assign rise    = sk_s[1] & ~sk_s[2];
    assign si      = si_s[1];
    assign x16     = org_s[1];
    assign abits   = x16 ? eec_pkg::ABITS_X16 : eec_pkg::ABITS_X8;
    assign dbits   = x16 ? eec_pkg::DBITS_X16 : eec_pkg::DBITS_X8;
    assign a_sh    = {addr_r[7:0], si};
    assign d_sh    = {data_r[14:0], si};
    assign top2    = x16 ? a_sh[7:6] : a_sh[8:7];
    assign na      = addr_r + 9'h001;

    // x16 words are stored high byte first at an even byte index
    function automatic logic [15:0] rd_word(input logic [8:0] a);
        if (x16)
            rd_word = {mem_r[{a[7:0], 1'b0}], mem_r[{a[7:0], 1'b1}]};
        else
            rd_word = {mem_r[a], 8'h00};
    endfunction : rd_word

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        op_nxt   = op_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        dout_nxt = dout_r;
        unl_nxt  = unl_r;
        busy_nxt = busy_r;
        stat_nxt = stat_r;
        wcnt_nxt = wcnt_r;
        mem_nxt  = mem_r;
        do_wr    = 1'b0;
        do_all   = 1'b0;
        wv       = 16'hFFFF;
        wa       = addr_r;
        rw       = 16'h0000;
        if (busy_r) begin
            wcnt_nxt = wcnt_r + 22'h000001;
            if (wcnt_r == PROG_CYCLES - 22'h000001)
                busy_nxt = 1'b0;
        end
        if (!cs) begin
            st_nxt   = S_IDLE;
            dout_nxt = 1'b0;
            // polling ends once a finished cycle has been seen
            if (cs_fall && !busy_r)
                stat_nxt = 1'b0;
        end else begin
            if (stat_r && st_r == S_IDLE)
                dout_nxt = ~busy_r;
            if (rise) begin
                case (st_r)
                    S_IDLE: begin
                        // zeros before the lead bit are idle clocks
                        if (si && !busy_r) begin
                            st_nxt   = S_OP;
                            cnt_nxt  = 5'h00;
                            stat_nxt = 1'b0;
                            dout_nxt = 1'b0;
                        end
                    end
                    S_OP: begin
                        op_nxt  = {op_r[0], si};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == 5'h01) begin
                            st_nxt  = S_ADDR;
                            cnt_nxt = 5'h00;
                        end
                    end
                    S_ADDR: begin
                        addr_nxt = a_sh;
                        cnt_nxt  = cnt_r + 5'h01;
                        if (cnt_r == abits - 5'h01) begin
                            cnt_nxt = 5'h00;
                            st_nxt  = S_SKIP;
                            wa      = a_sh;
                            case (op_r)
                                eec_pkg::OP_READ: begin
                                    st_nxt   = S_READ;
                                    dout_nxt = 1'b0;
                                    data_nxt = rd_word(a_sh);
                                end
                                eec_pkg::OP_ERASE: do_wr = unl_r;
                                eec_pkg::OP_WRITE: st_nxt = S_DATA;
                                default: begin
                                    case (top2)
                                        eec_pkg::SUB_UNLOCK: unl_nxt = 1'b1;
                                        eec_pkg::SUB_LOCK:   unl_nxt = 1'b0;
                                        eec_pkg::SUB_CLEAR:  do_all = unl_r;
                                        default:             st_nxt = S_DATA;
                                    endcase
                                end
                            endcase
                        end
                    end
                    S_DATA: begin
                        data_nxt = d_sh;
                        cnt_nxt  = cnt_r + 5'h01;
                        if (cnt_r == dbits - 5'h01) begin
                            st_nxt = S_SKIP;
                            wv     = x16 ? d_sh : {8'h00, d_sh[7:0]};
                            // refused silently while locked
                            if (op_r == eec_pkg::OP_WRITE)
                                do_wr = unl_r;
                            else
                                do_all = unl_r;
                        end
                    end
                    S_READ: begin
                        // reads run on through following addresses
                        if (cnt_r == dbits) begin
                            rw       = rd_word(na);
                            addr_nxt = na;
                            dout_nxt = rw[15];
                            data_nxt = {rw[14:0], 1'b0};
                            cnt_nxt  = 5'h01;
                        end else begin
                            dout_nxt = data_r[15];
                            data_nxt = {data_r[14:0], 1'b0};
                            cnt_nxt  = cnt_r + 5'h01;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (do_wr || do_all) begin
            busy_nxt = 1'b1;
            stat_nxt = 1'b1;
            wcnt_nxt = 22'h000000;
            for (int i = 0; i < eec_pkg::MEM_BYTES; i++) begin
                if (do_all || (x16 ? (9'(i) >> 1) == {1'b0, wa[7:0]} : 9'(i) == wa))
                    mem_nxt[i] = (x16 && !i[0]) ? wv[15:8] : wv[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r   <= S_IDLE;
            cnt_r  <= 5'h00;
            op_r   <= 2'h0;
            addr_r <= 9'h000;
            data_r <= 16'h0000;
            dout_r <= 1'b0;
            unl_r  <= 1'b0;
            busy_r <= 1'b0;
            stat_r <= 1'b0;
            wcnt_r <= 22'h000000;
            for (int i = 0; i < eec_pkg::MEM_BYTES; i++)
                mem_r[i] <= eec_pkg::ERASED;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            op_r   <= op_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            dout_r <= dout_nxt;
            unl_r  <= unl_nxt;
            busy_r <= busy_nxt;
            stat_r <= stat_nxt;
            wcnt_r <= wcnt_nxt;
            mem_r  <= mem_nxt;
        end
    end

    assign link.serial_out = dout_r;
    assign unlocked        = unl_r;
    assign busy            = busy_r;
endmodule : eec_device

//--- eec_host.sv
/*
 * Controlling end: turns user commands into serial frames, polls the
 * program cycle and buffers read words in a FIFO.
 * Assumes serial_out is asynchronous to core_clk.
 */
`timescale 1ns/1ns
module eec_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  buf_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   n_r, n_nxt;
    logic          push, pop;

    assign in_ready  = n_r != (AW+1)'(D);
    assign out_valid = n_r != '0;
    assign out_data  = buf_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? (wp_r == AW'(D - 1) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? (rp_r == AW'(D - 1) ? '0 : rp_r + 1'b1) : rp_r;
        n_nxt  = n_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            n_r  <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            n_r  <= n_nxt;
        end
    end

    // storage needs no reset: empty entries are never presented
    always_ff @(posedge core_clk) begin
        if (push)
            buf_r[wp_r] <= in_data;
    end
endmodule : eec_fifo

module eec_host (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire eec_pkg::eec_cmd_t cmd_op,
    input  wire logic [8:0]        cmd_addr,
    input  wire logic [15:0]       cmd_data,
    input  wire logic              wide_mode,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic [15:0]            rd_data,
    eec_link_if.host               link
);
    typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_PUSH, H_GAP, H_POLL} eec_hst_t;
    localparam int FW = eec_pkg::FRAME_W;

    eec_hst_t        st_r, st_nxt;
    logic [FW-1:0]   fr_r, fr_nxt, fr_new;
    logic [4:0]      bit_r, bit_nxt, nb_r, nb_nxt, rs_r, rs_nxt;
    logic [6:0]      ph_r, ph_nxt;
    logic            cs_r, cs_nxt, sk_r, sk_nxt, org_r, org_nxt;
    logic            rd_r, rd_nxt, poll_r, poll_nxt, unl_r, unl_nxt;
    logic            rdy_r, rdy_nxt, fv_r, fv_nxt, fin_rdy;
    logic [15:0]     sr_r, sr_nxt;
    logic [1:0]      so_s;
    logic [4:0]      ab, db;
    logic            wrd, prog;
    logic [1:0]      opc, sub;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            so_s <= 2'h0;
        else
            so_s <= {so_s[0], link.serial_out};
    end

    assign ab   = wide_mode ? eec_pkg::ABITS_X16 : eec_pkg::ABITS_X8;
    assign db   = wide_mode ? eec_pkg::DBITS_X16 : eec_pkg::DBITS_X8;
    assign wrd  = cmd_op == eec_pkg::EEC_WRITE || cmd_op == eec_pkg::EEC_FILL;
    assign prog = wrd || cmd_op == eec_pkg::EEC_ERASE || cmd_op == eec_pkg::EEC_CLEAR;

    always_comb begin
        case (cmd_op)
            eec_pkg::EEC_READ:   {opc, sub} = {eec_pkg::OP_READ, 2'h0};
            eec_pkg::EEC_ERASE:  {opc, sub} = {eec_pkg::OP_ERASE, 2'h0};
            eec_pkg::EEC_WRITE:  {opc, sub} = {eec_pkg::OP_WRITE, 2'h0};
            eec_pkg::EEC_UNLOCK: {opc, sub} = {eec_pkg::OP_SUB, eec_pkg::SUB_UNLOCK};
            eec_pkg::EEC_LOCK:   {opc, sub} = {eec_pkg::OP_SUB, eec_pkg::SUB_LOCK};
            eec_pkg::EEC_CLEAR:  {opc, sub} = {eec_pkg::OP_SUB, eec_pkg::SUB_CLEAR};
            default:             {opc, sub} = {eec_pkg::OP_SUB, eec_pkg::SUB_FILL};
        endcase
        // left-justify lead bit, opcode, address and data
        fr_new = {1'b1, opc, (opc == eec_pkg::OP_SUB) ? {sub, 7'h00} : cmd_addr, 16'h0000};
        if (wide_mode)
            fr_new = {fr_new[27:25], (opc == eec_pkg::OP_SUB) ? {sub, 6'h00} : cmd_addr[7:0],
                      cmd_data, 1'b0};
        else
            fr_new = {fr_new[27:16], cmd_data[7:0], 8'h00};
    end

    always_comb begin
        st_nxt   = st_r;
        fr_nxt   = fr_r;
        bit_nxt  = bit_r;
        nb_nxt   = nb_r;
        rs_nxt   = rs_r;
        ph_nxt   = ph_r;
        cs_nxt   = cs_r;
        sk_nxt   = sk_r;
        org_nxt  = wide_mode;
        rd_nxt   = rd_r;
        poll_nxt = poll_r;
        unl_nxt  = unl_r;
        rdy_nxt  = rdy_r;
        fv_nxt   = fv_r;
        sr_nxt   = sr_r;
        case (st_r)
            H_IDLE: begin
                if (cmd_valid && rdy_r) begin
                    rdy_nxt  = 1'b0;
                    st_nxt   = H_SHIFT;
                    cs_nxt   = 1'b1;
                    sk_nxt   = 1'b0;
                    ph_nxt   = 7'h00;
                    bit_nxt  = 5'h00;
                    fr_nxt   = fr_new;
                    rd_nxt   = cmd_op == eec_pkg::EEC_READ;
                    rs_nxt   = eec_pkg::HEAD_BITS + ab;
                    nb_nxt   = eec_pkg::HEAD_BITS + ab
                             + ((wrd || cmd_op == eec_pkg::EEC_READ) ? db : 5'h00);
                    // a refused program command never shows busy, so do not poll
                    poll_nxt = prog && unl_r;
                    if (cmd_op == eec_pkg::EEC_UNLOCK)
                        unl_nxt = 1'b1;
                    if (cmd_op == eec_pkg::EEC_LOCK)
                        unl_nxt = 1'b0;
                end
            end
            H_SHIFT: begin
                ph_nxt = ph_r + 7'h01;
                if (ph_r == 7'(eec_pkg::SKH_CYC - 1)) begin
                    ph_nxt = 7'h00;
                    sk_nxt = ~sk_r;
                    if (sk_r) begin
                        if (rd_r && bit_r >= rs_r)
                            sr_nxt = {sr_r[14:0], so_s[1]};
                        fr_nxt  = {fr_r[FW-2:0], 1'b0};
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == nb_r - 5'h01) begin
                            cs_nxt = 1'b0;
                            st_nxt = rd_r ? H_PUSH : H_GAP;
                            fv_nxt = rd_r;
                        end
                    end
                end
            end
            H_PUSH: begin
                // back-pressure: the link stays idle until the FIFO takes the word
                if (fin_rdy) begin
                    fv_nxt = 1'b0;
                    st_nxt = H_GAP;
                end
            end
            H_GAP: begin
                ph_nxt = ph_r + 7'h01;
                if (ph_r == 7'(eec_pkg::CS_CYC - 1)) begin
                    ph_nxt = 7'h00;
                    if (poll_r) begin
                        poll_nxt = 1'b0;
                        cs_nxt   = 1'b1;
                        st_nxt   = H_POLL;
                    end else begin
                        rdy_nxt = 1'b1;
                        st_nxt  = H_IDLE;
                    end
                end
            end
            H_POLL: begin
                if (so_s[1]) begin
                    cs_nxt = 1'b0;
                    st_nxt = H_GAP;
                end
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r   <= H_IDLE;
            fr_r   <= '0;
            bit_r  <= 5'h00;
            nb_r   <= 5'h00;
            rs_r   <= 5'h00;
            ph_r   <= 7'h00;
            cs_r   <= 1'b0;
            sk_r   <= 1'b0;
            org_r  <= 1'b0;
            rd_r   <= 1'b0;
            poll_r <= 1'b0;
            unl_r  <= 1'b0;
            rdy_r  <= 1'b1;
            fv_r   <= 1'b0;
            sr_r   <= 16'h0000;
        end else begin
            st_r   <= st_nxt;
            fr_r   <= fr_nxt;
            bit_r  <= bit_nxt;
            nb_r   <= nb_nxt;
            rs_r   <= rs_nxt;
            ph_r   <= ph_nxt;
            cs_r   <= cs_nxt;
            sk_r   <= sk_nxt;
            org_r  <= org_nxt;
            rd_r   <= rd_nxt;
            poll_r <= poll_nxt;
            unl_r  <= unl_nxt;
            rdy_r  <= rdy_nxt;
            fv_r   <= fv_nxt;
            sr_r   <= sr_nxt;
        end
    end

    eec_fifo #(.W(16), .D(8)) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (fv_r),
        .in_ready  (fin_rdy),
        .in_data   (org_r ? sr_r : {8'h00, sr_r[7:0]}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign cmd_ready             = rdy_r;
    assign link.chip_select      = cs_r;
    assign link.shift_clock      = sk_r;
    assign link.serial_in        = fr_r[FW-1];
    assign link.width_select_pin = org_r;
endmodule : eec_host

//--- eec_link_sva.sv
/* checker for the three-wire link and the memory end's status flags.
   assumes one core clock and an active-high asynchronous reset. */
`timescale 1ns/1ns
module eec_link_sva #(
    parameter logic [21:0] PROG_CYCLES = 22'(eec_pkg::WP_CYC)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic width_select_pin,
    input wire logic unlocked,
    input wire logic busy
);
    logic [7:0]  cs_lo_r, cs_lo_nxt, sk_n_r, sk_n_nxt;
    logic [21:0] bz_r, bz_nxt;
    logic        sk_q_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // cs_lo_r and sk_n_r saturate so a long idle never wraps into a false short gap
    always_comb begin
        cs_lo_nxt = chip_select ? 8'h00 : cs_lo_r + {7'h00, cs_lo_r != 8'hFF};
        sk_n_nxt  = (shift_clock != sk_q_r) ? 8'h00 : sk_n_r + {7'h00, sk_n_r != 8'hFF};
        bz_nxt    = busy ? bz_r + 22'h1 : 22'h0;
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_lo_r <= 8'hFF;
            sk_n_r  <= 8'hFF;
            bz_r    <= 22'h0;
            sk_q_r  <= 1'b0;
        end else begin
            cs_lo_r <= cs_lo_nxt;
            sk_n_r  <= sk_n_nxt;
            bz_r    <= bz_nxt;
            sk_q_r  <= shift_clock;
        end
    end
    chk_rst_idle: assert property ($fell(sys_rst) |-> !unlocked && !busy && !serial_out)
        else $error("flags not idle after reset");
    chk_locked_quiet: assert property (!unlocked && !busy |=> !busy)
        else $error("program cycle started while locked");
    chk_lock_in_frame: assert property ($changed(unlocked) |-> chip_select)
        else $error("lock state changed outside a frame");
    chk_clock_framed: assert property (!chip_select |-> !shift_clock)
        else $error("shift clock high while deselected");
    chk_din_stable: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
        else $error("serial input moved while shift clock high");
    chk_width_fixed: assert property (chip_select |-> $stable(width_select_pin))
        else $error("width select moved inside a frame");
    chk_half_period: assert property (shift_clock != sk_q_r |-> sk_n_r >= 8'h3E)
        else $error("shift clock phase too short");
    chk_cs_gap: assert property ($rose(chip_select) |-> cs_lo_r >= 8'h3E)
        else $error("chip select low time too short");
    chk_busy_len: assert property ($fell(busy) |-> bz_r >= PROG_CYCLES - 22'h1
        && bz_r <= PROG_CYCLES + 22'h1)
        else $error("program cycle length wrong");
    chk_status_ready: assert property ($fell(busy) && chip_select |-> ##[0:5] serial_out)
        else $error("ready status not shown");
    chk_out_release: assert property ($fell(chip_select) && !busy |-> ##[1:5] !serial_out)
        else $error("serial output not released");
endmodule : eec_link_sva

//--- serial_eeprom_command_decoder_tb_top.sv
/* bench top: both link ends joined, read words checked against a byte-array model.
   assumes a 250 MHz core clock and a shortened program cycle. */
`timescale 1ns/1ns
module serial_eeprom_command_decoder_tb_top;
    localparam logic [21:0] PROG = 22'hC8;
    logic              core_clk, sys_rst, cmd_valid, cmd_ready, wide_mode, rd_valid, rd_ready;
    logic              unlocked, busy, lk;
    eec_pkg::eec_cmd_t cmd_op;
    logic [8:0]        cmd_addr, a0;
    logic [15:0]       cmd_data, rd_data;
    logic [31:0]       seed;
    logic [7:0]        mem [512];
    logic [15:0]       exp_q [$];
    int                num_errors, checked;
    eec_link_if link ();
    eec_device #(.PROG_CYCLES(PROG)) i_eec_device (.core_clk(core_clk), .sys_rst(sys_rst),
        .link(link), .unlocked(unlocked), .busy(busy));
    eec_host i_eec_host (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .wide_mode(wide_mode), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .link(link));
    eec_link_sva #(.PROG_CYCLES(PROG)) i_eec_link_sva (.core_clk(core_clk), .sys_rst(sys_rst),
        .chip_select(link.chip_select), .shift_clock(link.shift_clock),
        .serial_in(link.serial_in), .serial_out(link.serial_out),
        .width_select_pin(link.width_select_pin), .unlocked(unlocked), .busy(busy));
    always #2 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // a word pops at the next posedge
    task automatic drain();
        int n;
        for (n = 0; n < 9000 && exp_q.size() > 0; n++) begin
            @(negedge core_clk);
            rd_ready = ^rnd();
            if (rd_ready && rd_valid === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data);
        end
        @(negedge core_clk);
        rd_ready = 1'b0;
        chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
        if (n == 9000) begin
            num_errors++;
            results();
        end
    endtask : drain
    task automatic cmd(input eec_pkg::eec_cmd_t op, input logic [8:0] a,
                       input logic [15:0] d = 16'h0000);
        int n, b;
        b = wide_mode ? 2 * int'(a[7:0]) : int'(a);
        if (op == eec_pkg::EEC_READ && exp_q.size() == 8) drain();
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 20000 && (n < 2 || cmd_ready !== 1'b1); n++) @(negedge core_clk);
        if (n == 20000) begin
            num_errors++;
            results();
        end
        case (op)
            eec_pkg::EEC_UNLOCK: lk = 1'b0;
            eec_pkg::EEC_LOCK: lk = 1'b1;
            eec_pkg::EEC_READ: exp_q.push_back(wide_mode ? {mem[b], mem[b+1]} : {8'h00, mem[b]});
            default: if (!lk) begin
                for (int i = 0; i < 512; i++) begin
                    if (op == eec_pkg::EEC_CLEAR || op == eec_pkg::EEC_FILL || i == b
                        || (wide_mode && i == b + 1)) begin
                        mem[i] = (op == eec_pkg::EEC_ERASE || op == eec_pkg::EEC_CLEAR) ? 8'hFF
                            : ((wide_mode && i % 2 == 0) ? d[15:8] : d[7:0]);
                    end
                end
            end
        endcase
        chk("flags", {14'h0000, !lk, 1'b0}, {14'h0000, unlocked, busy});
    endtask : cmd
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = eec_pkg::EEC_READ;
        cmd_addr = 9'h000;
        cmd_data = 16'h0000;
        wide_mode = 1'b0;
        rd_ready = 1'b0;
        seed = 32'h0000004B;
        lk = 1'b1;
        num_errors = 0;
        checked = 0;
        for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        // reads queue across both widths so the FIFO fills
        for (int m = 0; m < 2; m++) begin
            wide_mode = m[0];
            repeat (2) @(negedge core_clk);
            a0 = 9'(rnd());
            cmd(eec_pkg::EEC_WRITE, a0, 16'(rnd()));
            cmd(eec_pkg::EEC_READ, a0);
            cmd(eec_pkg::EEC_UNLOCK, 9'h000);
            cmd(eec_pkg::EEC_WRITE, 9'h1FF, 16'(rnd()));
            cmd(eec_pkg::EEC_WRITE, a0, 16'(rnd()));
            cmd(eec_pkg::EEC_READ, 9'h1FF);
            cmd(eec_pkg::EEC_READ, a0);
            cmd(eec_pkg::EEC_ERASE, 9'h1FF);
            cmd(eec_pkg::EEC_READ, 9'h1FF);
            cmd(eec_pkg::EEC_FILL, a0, 16'(rnd()));
            cmd(eec_pkg::EEC_READ, 9'(rnd()));
            cmd(eec_pkg::EEC_CLEAR, a0);
            cmd(eec_pkg::EEC_READ, a0);
            cmd(eec_pkg::EEC_LOCK, 9'h000);
            cmd(eec_pkg::EEC_WRITE, a0, 16'(rnd()));
            cmd(eec_pkg::EEC_READ, a0);
        end
        drain();
        results();
    end
endmodule : serial_eeprom_command_decoder_tb_top
